// [logic/amcs_params.svh]
// register offsets, command words and field positions of the mode sequencer
// assumes a serial write port delivering an 8-bit address and 16-bit data
//
// Contract
// - reset by pin pulse or soft-reset word
// - power-down by pin high or 0x0200 write
// - active again with pin low and a zero write
// - mode register accepts three documented words, only while powered down
// - input selections take effect without power-down
// - inputs at two addresses, one-hot byte codes
// - single mode: 1010 selects input four
// - quad mode: 1008/0402 routes inputs reversed
// - timing uses rising clock edge only
`ifndef AMCS_PARAMS_SVH
`define AMCS_PARAMS_SVH
`define AMCS_ADDR_SOFT_RESET 8'h00
`define AMCS_ADDR_POWER_DOWN 8'h0F
`define AMCS_ADDR_MODE_DIV 8'h31
`define AMCS_ADDR_INSEL_LO 8'h3A
`define AMCS_ADDR_INSEL_HI 8'h3B
`define AMCS_ADDR_PHASE 8'h42
`define AMCS_SOFT_RESET_WORD 16'h0001
`define AMCS_PD_ON_WORD 16'h0200
`define AMCS_PD_OFF_WORD 16'h0000
`define AMCS_PD_BIT 9
`define AMCS_MODE_SINGLE 16'h0001
`define AMCS_MODE_DUAL 16'h0102
`define AMCS_MODE_QUAD 16'h0204
`define AMCS_MODE_RESET 16'h0001
`define AMCS_INSEL_RESET 16'h0000
`define AMCS_PHASE_RESET 16'h0000
`endif

// [logic/amcs_pkg.sv]
// types shared by the mode sequencer files
package amcs_pkg;
	typedef enum logic [1:0] {
		AMCS_SINGLE,
		AMCS_DUAL,
		AMCS_QUAD
	} amcs_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} amcs_wr_t;

	typedef struct packed {
		logic [3:0] ch4;
		logic [3:0] ch3;
		logic [3:0] ch2;
		logic [3:0] ch1;
	} amcs_route_t;
endpackage

// [logic/amcs_route_decode.sv]
// decodes input-select bytes into per-channel analog input one-hot routes
// takes the unregistered next select words; the caller registers the decoded route
`timescale 1ns/1ps
`include "amcs_params.svh"
module amcs_route_decode (
	input wire logic [15:0] sel_lo,
	input wire logic [15:0] sel_hi,
	output amcs_pkg::amcs_route_t route
);
	logic [7:0] bytes_w [4];
	logic [3:0] hot_w [4];

	assign bytes_w[0] = sel_lo[15:8];
	assign bytes_w[1] = sel_lo[7:0];
	assign bytes_w[2] = sel_hi[15:8];
	assign bytes_w[3] = sel_hi[7:0];

	// bit 1,2,3,4 of a byte code mean input 1..4 (0x02..0x10)
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_byte
			assign hot_w[g] = bytes_w[g][4:1];
		end
	endgenerate

	assign route.ch1 = hot_w[0];
	assign route.ch2 = hot_w[1];
	assign route.ch3 = hot_w[2];
	assign route.ch4 = hot_w[3];
endmodule

// [logic/amcs_seq.sv]
// mode, power-down and input-route control of the interleaved converter
// assumes the serial shifter delivers one write strobe per transfer
`timescale 1ns/1ps
`include "amcs_params.svh"
module amcs_seq (
	input wire logic clk,
	input wire logic nrst,
	input wire logic chip_clear_n_pin,
	input wire logic sleep_pin,
	input wire logic wr_stb,
	input wire amcs_pkg::amcs_wr_t wr,
	output amcs_pkg::amcs_mode_t mode_r,
	output logic [2:0] clk_div_r,
	output logic powered_down_r,
	output logic mode_err_r,
	output amcs_pkg::amcs_route_t route_r,
	output logic [15:0] phase_r,
	output logic [15:0] mode_word_r,
	output logic [15:0] insel_lo_r,
	output logic [15:0] insel_hi_r
);
	logic clear_w;
	logic pd_reg_r;
	logic pd_nxt;
	logic hit_w;
	amcs_pkg::amcs_route_t route_nxt;
	logic [15:0] lo_nxt;
	logic [15:0] hi_nxt;

	// ===============================================
	// reset
	// pin is taken synchronous; a low level holds defaults
	assign clear_w = !nrst || !chip_clear_n_pin
		|| (wr_stb && wr.addr == `AMCS_ADDR_SOFT_RESET
		&& wr.data == `AMCS_SOFT_RESET_WORD);

	// ===============================================
	// power-down
	assign hit_w = wr_stb && wr.addr == `AMCS_ADDR_POWER_DOWN;
	always_comb begin
		pd_nxt = pd_reg_r;
		if (hit_w) begin
			pd_nxt = wr.data[`AMCS_PD_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (clear_w) begin
			pd_reg_r <= 1'b0;
		end else begin
			pd_reg_r <= pd_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (clear_w) begin
			powered_down_r <= 1'b0;
		end else begin
			powered_down_r <= pd_nxt || sleep_pin;
		end
	end

	// ===============================================
	// mode and divider
	// unknown words are refused and flagged, keeping the old mode
	always_ff @(posedge clk) begin
		if (clear_w) begin
			mode_r <= amcs_pkg::AMCS_SINGLE;
			clk_div_r <= 3'h1;
			mode_word_r <= `AMCS_MODE_RESET;
			mode_err_r <= 1'b0;
		end else if (wr_stb && wr.addr == `AMCS_ADDR_MODE_DIV) begin
			// switching while active would skip branch resync
			if (!powered_down_r) begin
				mode_err_r <= 1'b1;
			end else begin
				mode_err_r <= 1'b0;
				case (wr.data)
				`AMCS_MODE_SINGLE: begin
					mode_r <= amcs_pkg::AMCS_SINGLE;
					clk_div_r <= 3'h1;
					mode_word_r <= wr.data;
				end
				`AMCS_MODE_DUAL: begin
					mode_r <= amcs_pkg::AMCS_DUAL;
					clk_div_r <= 3'h2;
					mode_word_r <= wr.data;
				end
				`AMCS_MODE_QUAD: begin
					mode_r <= amcs_pkg::AMCS_QUAD;
					clk_div_r <= 3'h4;
					mode_word_r <= wr.data;
				end
				default: begin
					mode_err_r <= 1'b1;
				end
				endcase
			end
		end
	end

	// ===============================================
	// bit-clock phase
	always_ff @(posedge clk) begin
		if (clear_w) begin
			phase_r <= `AMCS_PHASE_RESET;
		end else if (wr_stb && wr.addr == `AMCS_ADDR_PHASE) begin
			phase_r <= wr.data;
		end
	end

	// ===============================================
	// input selection, live while active
	always_comb begin
		lo_nxt = insel_lo_r;
		hi_nxt = insel_hi_r;
		if (wr_stb && wr.addr == `AMCS_ADDR_INSEL_LO) begin
			lo_nxt = wr.data;
		end
		if (wr_stb && wr.addr == `AMCS_ADDR_INSEL_HI) begin
			hi_nxt = wr.data;
		end
	end

	amcs_route_decode u_dec (
		.sel_lo(lo_nxt),
		.sel_hi(hi_nxt),
		.route(route_nxt)
	);

	always_ff @(posedge clk) begin
		if (clear_w) begin
			insel_lo_r <= `AMCS_INSEL_RESET;
			insel_hi_r <= `AMCS_INSEL_RESET;
			route_r <= '0;
		end else begin
			insel_lo_r <= lo_nxt;
			insel_hi_r <= hi_nxt;
			route_r <= route_nxt;
		end
	end

	// ===============================================
	// checks
	a_soft_reset_pd: assert property (@(posedge clk) disable iff (!nrst)
		wr_stb && wr.addr == `AMCS_ADDR_SOFT_RESET
		&& wr.data == `AMCS_SOFT_RESET_WORD |=> !pd_reg_r
		&& mode_word_r == `AMCS_MODE_RESET)
		else $error("soft reset did not restore defaults");
	a_pd_enter: assert property (@(posedge clk) disable iff (!nrst)
		chip_clear_n_pin && sleep_pin |=> powered_down_r)
		else $error("sleep pin did not power down");
	a_pd_leave: assert property (@(posedge clk) disable iff (!nrst)
		chip_clear_n_pin && !sleep_pin && hit_w
		&& wr.data == `AMCS_PD_OFF_WORD |=> !powered_down_r)
		else $error("zero write did not wake device");
	a_mode_dual: assert property (@(posedge clk) disable iff (!nrst)
		chip_clear_n_pin && powered_down_r && wr_stb
		&& wr.addr == `AMCS_ADDR_MODE_DIV && wr.data == `AMCS_MODE_DUAL
		|=> mode_r == amcs_pkg::AMCS_DUAL && clk_div_r == 3'h2)
		else $error("dual mode word not applied");
	a_mode_guard: assert property (@(posedge clk) disable iff (!nrst)
		!powered_down_r && !clear_w |=> $stable(mode_r))
		else $error("mode changed while active");
	a_route_now: assert property (@(posedge clk) disable iff (!nrst)
		chip_clear_n_pin && wr_stb && wr.addr == `AMCS_ADDR_INSEL_LO
		&& wr.data == 16'h0202 && !(wr.data == 16'h0 && 1'b0)
		|=> route_r.ch1 == 4'h1 && route_r.ch2 == 4'h1)
		else $error("input select not immediate");
	a_quad_route: assert property (@(posedge clk) disable iff (!nrst)
		insel_lo_r == 16'h1008 && insel_hi_r == 16'h0402
		|-> route_r == 16'h1248)
		else $error("quad route mismatch");
	a_single_in4: assert property (@(posedge clk) disable iff (!nrst)
		insel_lo_r == 16'h1010 && insel_hi_r == 16'h1010
		|-> route_r.ch1 == 4'h8)
		else $error("single route mismatch");
	c_mode_quad: cover property (@(posedge clk)
		mode_r == amcs_pkg::AMCS_QUAD);
	c_wake: cover property (@(posedge clk)
		powered_down_r ##1 !powered_down_r);
	c_mode_err: cover property (@(posedge clk) mode_err_r);
endmodule

// [tb/amcs_host.sv]
// host model: issues completed serial writes to the sequencer
// assumes callers run just after a rising edge of clk
`timescale 1ns/1ps
module amcs_host (
	input wire logic clk,
	output logic wr_stb,
	output amcs_pkg::amcs_wr_t wr
);
	initial begin
		wr_stb = 1'b0;
		wr = 24'h000000;
	end
	// strobe held for back-to-back writes
	task automatic put(input logic [7:0] a, input logic [15:0] d);
		wr_stb <= 1'b1;
		wr <= {a, d};
		@(posedge clk);
	endtask
	// released bus shows inverted data, never a stale word
	task automatic idle();
		wr_stb <= 1'b0;
		wr <= ~wr;
		@(posedge clk);
	endtask
endmodule

// [tb/tb_amcs_seq.sv]
// table-driven bench of the mode sequencer
// assumes the host model drives the write port
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin \
$display("unexpected %s exp %h got %h", n, e, s); fails++; end end
module tb_amcs_seq;
	typedef struct packed {
		logic [7:0] a;
		logic [15:0] d;
		logic [6:0] o;
		logic [15:0] r;
	} amcs_row_t;
	// o is {mode, divider, powered down, refused}
	localparam amcs_row_t rows [20] = '{
		'{8'h0F, 16'h0200, 7'h06, 16'h0000},
		'{8'h31, 16'h0102, 7'h2A, 16'h0000},
		'{8'h0F, 16'h0000, 7'h28, 16'h0000},
		'{8'h3A, 16'h0202, 7'h28, 16'h0011},
		'{8'h3B, 16'h0808, 7'h28, 16'h4411},
		'{8'h31, 16'h0204, 7'h29, 16'h4411},
		'{8'h0F, 16'h0200, 7'h2B, 16'h4411},
		'{8'h31, 16'h0204, 7'h52, 16'h4411},
		'{8'h0F, 16'h0000, 7'h50, 16'h4411},
		'{8'h3A, 16'h1008, 7'h50, 16'h4448},
		'{8'h3B, 16'h0402, 7'h50, 16'h1248},
		'{8'h0F, 16'h0200, 7'h52, 16'h1248},
		'{8'h31, 16'h0001, 7'h06, 16'h1248},
		'{8'h0F, 16'h0000, 7'h04, 16'h1248},
		'{8'h3A, 16'h1010, 7'h04, 16'h1288},
		'{8'h3B, 16'h1010, 7'h04, 16'h8888},
		'{8'h0F, 16'h0200, 7'h06, 16'h8888},
		'{8'h31, 16'h0003, 7'h07, 16'h8888},
		'{8'h55, 16'h1234, 7'h07, 16'h8888},
		'{8'h00, 16'h0001, 7'h04, 16'h0000}
	};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic chip_clear_n_pin = 1'b1;
	logic sleep_pin = 1'b0;
	logic wr_stb;
	amcs_pkg::amcs_wr_t wr;
	amcs_pkg::amcs_mode_t mode_r;
	logic [2:0] clk_div_r;
	logic powered_down_r, mode_err_r;
	amcs_pkg::amcs_route_t route_r;
	logic [15:0] phase_r, mode_word_r, insel_lo_r, insel_hi_r;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	amcs_host amcs_host_i (.clk(clk), .wr_stb(wr_stb), .wr(wr));
	amcs_seq amcs_seq_i (.clk(clk), .nrst(nrst),
		.chip_clear_n_pin(chip_clear_n_pin), .sleep_pin(sleep_pin),
		.wr_stb(wr_stb), .wr(wr), .mode_r(mode_r),
		.clk_div_r(clk_div_r), .powered_down_r(powered_down_r),
		.mode_err_r(mode_err_r), .route_r(route_r), .phase_r(phase_r),
		.mode_word_r(mode_word_r), .insel_lo_r(insel_lo_r),
		.insel_hi_r(insel_hi_r));
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ceiling well above the roughly 80 cycles of the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk) #1;
		`CHK("mode word", 16'h0001, mode_word_r)
		@(posedge clk);
		// sequence of the table: sleep, mode, wake, inputs
		foreach (rows[i]) begin
			amcs_host_i.put(rows[i].a, rows[i].d);
			amcs_host_i.idle();
			#1 `CHK("state", {rows[i].o, rows[i].r}, {mode_r, clk_div_r,
				powered_down_r, mode_err_r, route_r})
		end
		@(posedge clk);
		// back-to-back selects while active
		amcs_host_i.put(8'h3A, 16'h0404);
		amcs_host_i.put(8'h3B, 16'h0202);
		amcs_host_i.put(8'h42, 16'h00A5);
		#1 `CHK("route", 16'h1122, route_r)
		`CHK("selects", 32'h04040202, {insel_lo_r, insel_hi_r})
		amcs_host_i.idle();
		#1 `CHK("phase", 16'h00A5, phase_r)
		@(posedge clk) sleep_pin <= 1'b1;
		@(posedge clk) #1 `CHK("pin sleep", 1'b1, powered_down_r)
		@(posedge clk) sleep_pin <= 1'b0;
		@(posedge clk) #1 `CHK("pin wake", 1'b0, powered_down_r)
		@(posedge clk) chip_clear_n_pin <= 1'b0;
		@(posedge clk) chip_clear_n_pin <= 1'b1;
		@(posedge clk) #1;
		`CHK("pin clear", 32'h00000000, {phase_r, route_r})
		final_report();
	end
endmodule
